/* File: shared/rcp_pkg.sv */
// Shared constants and carrier types for the reference clock and power mode block
package rcp_pkg;

  localparam int unsigned RCP_ADDR_W = 8;
  localparam int unsigned RCP_SRC_W = 3;

  // Register byte offsets
  localparam logic [RCP_ADDR_W-1:0] RCP_CTRL_OFS = 8'h00;
  localparam logic [RCP_ADDR_W-1:0] RCP_STAT_OFS = 8'h04;

  // Reference clock output control fields
  localparam int unsigned RCP_EN_BIT = 15;
  localparam int unsigned RCP_SLP_BIT = 13;
  localparam int unsigned RCP_SEL_BIT = 12;
  localparam int unsigned RCP_DIV_LSB = 8;
  localparam int unsigned RCP_DIV_W = 4;
  localparam int unsigned RCP_CTRL_W = 16;
  localparam logic [15:0] RCP_CTRL_RST = 16'h0000;
  localparam logic [15:0] RCP_CTRL_MASK = 16'hBF00;
  localparam int unsigned RCP_CTRL_LANE = 1;

  // Status fields
  localparam int unsigned RCP_STAT_MODE_LSB = 0;
  localparam int unsigned RCP_STAT_PEND_BIT = 2;
  localparam int unsigned RCP_STAT_CPU_BIT = 3;
  localparam int unsigned RCP_STAT_SRC_LSB = 4;

  localparam logic [1:0] RCP_RESP_OKAY = 2'h0;
  localparam logic [1:0] RCP_RESP_SLVERR = 2'h2;

  localparam int unsigned RCP_CLK_PERIOD_NS = 40;

  typedef enum logic [1:0] {
    RCP_RUN,
    RCP_IDLE,
    RCP_SLEEP,
    RCP_DSLEEP
  } rcp_mode_t;

  typedef struct packed {
    logic [RCP_ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [RCP_ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } rcp_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } rcp_axi_rsp_t;

  // Power-save instruction issue: exec is a one-cycle pulse
  typedef struct packed {
    logic exec;
    logic sleep_op;
  } rcp_psave_t;

  typedef struct packed {
    logic irq;
    logic wdt_timeout;
    logic dev_reset;
  } rcp_wake_t;

endpackage : rcp_pkg

/* File: core/rcp_refdiv.sv */
// Power-of-two divider that toggles the reference clock pin on base clock ticks
module rcp_refdiv import rcp_pkg::*; #(
  parameter int unsigned DIV_W = RCP_DIV_W,
  parameter int unsigned CNT_W = 15
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic base_tick,
  input wire logic [DIV_W-1:0] div_code,
  input wire logic run,
  output logic ref_q
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic out;
  } rcp_div_st_t;

  rcp_div_st_t s, d;
  logic [31:0] span;
  logic [CNT_W-1:0] lim;

  // One tick is one base half period, so code zero mirrors the base clock
  assign span = 32'h0000_0001 << div_code;
  assign lim = CNT_W'(span - 32'h0000_0001);

  always_comb begin
    d = s;
    if (!run) begin
      d.cnt = '0;
      d.out = 1'b0;
    end else if (base_tick) begin
      // Compare with >= so a smaller code written mid-count takes at once
      if (s.cnt >= lim) begin
        d.cnt = '0;
        d.out = ~s.out;
      end else begin
        d.cnt = s.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= d;
    end
  end

  assign ref_q = s.out;

endmodule : rcp_refdiv

/* File: core/rcp_top.sv */
// Reference clock output and instruction-based power mode controller
module rcp_top import rcp_pkg::*; #(
  parameter int unsigned PIN_W = 16,
  parameter int unsigned CNT_W = 15
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire rcp_axi_req_t axi_req,
  output rcp_axi_rsp_t axi_rsp,
  input wire rcp_psave_t psave,
  input wire rcp_wake_t wake_src,
  input wire logic deep_sleep_arm,
  input wire logic [RCP_SRC_W-1:0] cur_clk_src,
  input wire logic posc_tick,
  input wire logic sys_tick,
  input wire logic posc_configured,
  input wire logic wdt_enable,
  input wire logic fail_safe_clock_monitor_enable,
  input wire logic rtc_enable,
  input wire logic rtc_on_low_power_rc_osc,
  input wire logic deep_sleep_watchdog_enable,
  input wire logic [PIN_W-1:0] gpio_dir,
  input wire logic [PIN_W-1:0] gpio_out,
  output logic reference_clock_pin,
  output logic cpu_clk_en,
  output logic sys_clk_en,
  output logic periph_clk_en,
  output logic ext_periph_en,
  output logic posc_en,
  output logic low_power_rc_osc_en,
  output logic fail_safe_clock_monitor_active,
  output logic rtc_run,
  output logic deep_sleep_watchdog_run,
  output logic wdt_clear,
  output logic wake_pulse,
  output logic resume_isr,
  output logic [RCP_SRC_W-1:0] resume_clk_src,
  output logic [PIN_W-1:0] pin_dir,
  output logic [PIN_W-1:0] pin_out
);

  typedef struct packed {
    logic [RCP_CTRL_W-1:0] ctrl;
    rcp_mode_t mode;
    logic pend;
    logic [RCP_SRC_W-1:0] held_src;
    logic [PIN_W-1:0] pdir;
    logic [PIN_W-1:0] pout;
    logic cpu_en;
    logic sysclk_en;
    logic periph_en;
    logic ext_en;
    logic posc_en;
    logic low_power_rc_osc_en;
    logic fail_safe_clock_monitor_act;
    logic rtc_en;
    logic deep_sleep_watchdog_en;
    logic wdt_clr;
    logic wake;
    logic resume_isr;
    rcp_axi_rsp_t bus;
  } rcp_st_t;

  rcp_st_t s, d;
  logic ref_en, ref_slp, ref_sel, ref_run, base_tick, awake, wake_ev;
  logic [RCP_DIV_W-1:0] ref_div;
  logic [31:0] stat_word;

  assign ref_en = s.ctrl[RCP_EN_BIT];
  assign ref_slp = s.ctrl[RCP_SLP_BIT];
  assign ref_sel = s.ctrl[RCP_SEL_BIT];
  assign ref_div = s.ctrl[RCP_DIV_LSB +: RCP_DIV_W];
  assign awake = (s.mode == RCP_RUN) || (s.mode == RCP_IDLE);
  assign ref_run = ref_en && (awake || ref_slp);
  // Each base stops with its oscillator, so a gated source freezes the divider
  assign base_tick = ref_sel ? (posc_tick && s.posc_en)
                             : (sys_tick && s.sysclk_en);
  assign wake_ev = wake_src.irq || wake_src.wdt_timeout || wake_src.dev_reset
                   || s.pend;

  always_comb begin
    stat_word = '0;
    stat_word[RCP_STAT_MODE_LSB +: 2] = s.mode;
    stat_word[RCP_STAT_PEND_BIT] = s.pend;
    stat_word[RCP_STAT_CPU_BIT] = s.cpu_en;
    stat_word[RCP_STAT_SRC_LSB +: RCP_SRC_W] = s.held_src;
  end

  always_comb begin
    d = s;
    d.wdt_clr = 1'b0;
    d.wake = 1'b0;

    // Write: ready pulses for one cycle once both address and data are offered
    d.bus.awready = 1'b0;
    d.bus.wready = 1'b0;
    if (s.bus.bvalid && axi_req.bready) begin
      d.bus.bvalid = 1'b0;
    end
    if (s.bus.awready) begin
      d.bus.bvalid = 1'b1;
      d.bus.bresp = RCP_RESP_SLVERR;
      if (axi_req.awaddr[RCP_ADDR_W-1:2] == RCP_CTRL_OFS[RCP_ADDR_W-1:2]) begin
        d.bus.bresp = RCP_RESP_OKAY;
        if (axi_req.wstrb[RCP_CTRL_LANE]) begin
          d.ctrl[15:8] = axi_req.wdata[15:8] & RCP_CTRL_MASK[15:8];
        end
      end else if (axi_req.awaddr[RCP_ADDR_W-1:2] == RCP_STAT_OFS[RCP_ADDR_W-1:2]) begin
        d.bus.bresp = RCP_RESP_OKAY;
      end
    end else if (!s.bus.bvalid && axi_req.awvalid && axi_req.wvalid) begin
      d.bus.awready = 1'b1;
      d.bus.wready = 1'b1;
    end

    // Read
    d.bus.arready = 1'b0;
    if (s.bus.rvalid && axi_req.rready) begin
      d.bus.rvalid = 1'b0;
    end
    if (s.bus.arready) begin
      d.bus.rvalid = 1'b1;
      d.bus.rdata = '0;
      d.bus.rresp = RCP_RESP_SLVERR;
      if (axi_req.araddr[RCP_ADDR_W-1:2] == RCP_CTRL_OFS[RCP_ADDR_W-1:2]) begin
        d.bus.rresp = RCP_RESP_OKAY;
        d.bus.rdata[15:0] = s.ctrl & RCP_CTRL_MASK;
      end else if (axi_req.araddr[RCP_ADDR_W-1:2] == RCP_STAT_OFS[RCP_ADDR_W-1:2]) begin
        d.bus.rresp = RCP_RESP_OKAY;
        d.bus.rdata = stat_word;
      end
    end else if (!s.bus.rvalid && axi_req.arvalid) begin
      d.bus.arready = 1'b1;
    end

    // Mode sequencing
    case (s.mode)
      RCP_RUN: begin
        d.held_src = cur_clk_src;
        if (psave.exec) begin
          d.pend = wake_src.irq;
          d.wdt_clr = wdt_enable;
          if (!psave.sleep_op) begin
            d.mode = RCP_IDLE;
          end else if (deep_sleep_arm) begin
            d.mode = RCP_DSLEEP;
          end else begin
            d.mode = RCP_SLEEP;
          end
        end
      end
      RCP_IDLE, RCP_SLEEP: begin
        if (wake_ev) begin
          d.mode = RCP_RUN;
          d.wake = 1'b1;
          d.resume_isr = wake_src.irq || s.pend;
          d.pend = 1'b0;
        end
      end
      RCP_DSLEEP: begin
        // Only a device reset leaves deep sleep here
        if (wake_src.dev_reset) begin
          d.mode = RCP_RUN;
          d.wake = 1'b1;
          d.resume_isr = 1'b0;
          d.pend = 1'b0;
        end
      end
      default: begin
        d.mode = RCP_RUN;
      end
    endcase

    // Pins track software while awake, hold entry values otherwise
    if (awake) begin
      d.pdir = gpio_dir;
      d.pout = gpio_out;
    end

    // Clock enables follow the next mode so they line up with it
    case (d.mode)
      RCP_RUN: begin
        d.cpu_en = 1'b1;
        d.sysclk_en = 1'b1;
        d.periph_en = 1'b1;
        d.ext_en = 1'b1;
        d.posc_en = posc_configured;
        d.low_power_rc_osc_en = wdt_enable || fail_safe_clock_monitor_enable || (rtc_enable && rtc_on_low_power_rc_osc);
        d.fail_safe_clock_monitor_act = fail_safe_clock_monitor_enable;
        d.rtc_en = rtc_enable;
        d.deep_sleep_watchdog_en = 1'b0;
      end
      RCP_IDLE: begin
        d.cpu_en = 1'b0;
        d.sysclk_en = 1'b1;
        d.periph_en = 1'b1;
        d.ext_en = 1'b1;
        d.posc_en = posc_configured;
        d.low_power_rc_osc_en = wdt_enable || fail_safe_clock_monitor_enable || (rtc_enable && rtc_on_low_power_rc_osc);
        d.fail_safe_clock_monitor_act = fail_safe_clock_monitor_enable;
        d.rtc_en = rtc_enable;
        d.deep_sleep_watchdog_en = 1'b0;
      end
      RCP_SLEEP: begin
        d.cpu_en = 1'b0;
        d.sysclk_en = 1'b0;
        d.periph_en = 1'b0;
        d.ext_en = 1'b1;
        d.posc_en = posc_configured && ref_sel;
        d.low_power_rc_osc_en = wdt_enable || (rtc_enable && rtc_on_low_power_rc_osc);
        d.fail_safe_clock_monitor_act = 1'b0;
        d.rtc_en = rtc_enable;
        d.deep_sleep_watchdog_en = 1'b0;
      end
      default: begin
        d.cpu_en = 1'b0;
        d.sysclk_en = 1'b0;
        d.periph_en = 1'b0;
        d.ext_en = 1'b0;
        d.posc_en = 1'b0;
        d.low_power_rc_osc_en = rtc_enable && rtc_on_low_power_rc_osc;
        d.fail_safe_clock_monitor_act = 1'b0;
        d.rtc_en = rtc_enable;
        d.deep_sleep_watchdog_en = deep_sleep_watchdog_enable;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.ctrl <= RCP_CTRL_RST;
      s.mode <= RCP_RUN;
      s.cpu_en <= 1'b1;
      s.sysclk_en <= 1'b1;
      s.periph_en <= 1'b1;
      s.ext_en <= 1'b1;
    end else begin
      s <= d;
    end
  end

  rcp_refdiv #(
    .DIV_W(RCP_DIV_W),
    .CNT_W(CNT_W)
  ) u_refdiv (
    .aclk(aclk),
    .aresetn(aresetn),
    .base_tick(base_tick),
    .div_code(ref_div),
    .run(ref_run),
    .ref_q(reference_clock_pin)
  );

  assign axi_rsp = s.bus;
  assign cpu_clk_en = s.cpu_en;
  assign sys_clk_en = s.sysclk_en;
  assign periph_clk_en = s.periph_en;
  assign ext_periph_en = s.ext_en;
  assign posc_en = s.posc_en;
  assign low_power_rc_osc_en = s.low_power_rc_osc_en;
  assign fail_safe_clock_monitor_active = s.fail_safe_clock_monitor_act;
  assign rtc_run = s.rtc_en;
  assign deep_sleep_watchdog_run = s.deep_sleep_watchdog_en;
  assign wdt_clear = s.wdt_clr;
  assign wake_pulse = s.wake;
  assign resume_isr = s.resume_isr;
  assign resume_clk_src = s.held_src;
  assign pin_dir = s.pdir;
  assign pin_out = s.pout;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence enter_s;
    s.mode == RCP_RUN && psave.exec && !deep_sleep_arm;
  endsequence

  sequence pend_entry_s;
    enter_s ##0 wake_src.irq;
  endsequence

  pin_low_off_a: assert property (!ref_en |=> !reference_clock_pin)
    else $error("reference pin not low while disabled");

  ctrl_zero_bits_a: assert property (
    s.bus.arready && axi_req.araddr[RCP_ADDR_W-1:2] == RCP_CTRL_OFS[RCP_ADDR_W-1:2]
    |=> s.bus.rdata[14] == 1'b0 && s.bus.rdata[7:0] == 8'h00)
    else $error("unimplemented control bits read nonzero");

  sleep_clocks_a: assert property (
    enter_s ##0 psave.sleep_op |=> !cpu_clk_en && !sys_clk_en && !periph_clk_en)
    else $error("clocks still running after sleep entry");

  pins_frozen_a: assert property (
    s.mode == RCP_SLEEP && $past(s.mode) == RCP_SLEEP |-> $stable(pin_out)
    && $stable(pin_dir))
    else $error("pins changed during sleep");

  fail_safe_clock_monitor_sleep_a: assert property (s.mode == RCP_SLEEP |-> !fail_safe_clock_monitor_active)
    else $error("clock monitor active in sleep");

  posc_sleep_a: assert property (s.mode == RCP_SLEEP && !ref_sel |-> !posc_en)
    else $error("primary oscillator kept in sleep without select");

  wdt_clear_a: assert property (enter_s ##0 wdt_enable |=> wdt_clear ##1 !wdt_clear)
    else $error("watchdog clear pulse missing on entry");

  idle_periph_a: assert property (
    enter_s ##0 !psave.sleep_op |=> !cpu_clk_en && periph_clk_en && sys_clk_en)
    else $error("idle clock gating wrong");

  wake_fast_a: assert property (
    s.mode == RCP_IDLE && (wake_src.irq || wake_src.wdt_timeout || wake_src.dev_reset)
    |=> cpu_clk_en && wake_pulse)
    else $error("no wake one cycle after event");

  pend_wake_a: assert property (
    pend_entry_s |=> s.mode != RCP_RUN ##1 s.mode == RCP_RUN && resume_isr)
    else $error("coincident interrupt did not wake after entry");

  low_power_rc_osc_idle_a: assert property (s.mode == RCP_IDLE && $past(s.mode) == RCP_IDLE
    && $past(fail_safe_clock_monitor_enable) |-> low_power_rc_osc_en)
    else $error("low-power oscillator off in idle with monitor on");

  src_hold_a: assert property (
    s.mode == RCP_SLEEP && $past(s.mode) == RCP_SLEEP |-> $stable(resume_clk_src))
    else $error("held clock source changed during sleep");

endmodule : rcp_top

/* File: bench/rcp_refclk_sink.sv */
// Far-side model: an external device counting and timing reference clock edges
module rcp_refclk_sink (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic reference_clock_pin,
  output int rise_count,
  output int period
);
  timeunit 1ns;
  timeprecision 1ps;
  int since_q;
  logic last_q;
  // Period in aclk cycles between the last two rising edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rise_count <= 0;
      period <= 0;
      since_q <= 0;
      last_q <= 1'b0;
    end else begin
      last_q <= reference_clock_pin;
      since_q <= since_q + 1;
      if (reference_clock_pin && !last_q) begin
        rise_count <= rise_count + 1;
        period <= since_q + 1;
        since_q <= 0;
      end
    end
  end
endmodule : rcp_refclk_sink

/* File: bench/tb_rcp_top.sv */
// Self-checking bench for the reference clock and power mode block
module tb_rcp_top import rcp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, deep_sleep_arm, posc_tick, sys_tick, posc_configured;
  logic wdt_enable, fail_safe_clock_monitor_enable, rtc_enable, rtc_on_low_power_rc_osc, deep_sleep_watchdog_enable;
  rcp_axi_req_t axi_req;
  rcp_axi_rsp_t axi_rsp;
  rcp_psave_t psave;
  rcp_wake_t wake_src;
  logic [RCP_SRC_W-1:0] cur_clk_src, resume_clk_src;
  logic [15:0] gpio_dir, gpio_out, pin_dir, pin_out;
  logic reference_clock_pin, cpu_clk_en, sys_clk_en, periph_clk_en, ext_periph_en;
  logic posc_en, low_power_rc_osc_en, fail_safe_clock_monitor_active, rtc_run, deep_sleep_watchdog_run, wdt_clear, wake_pulse, resume_isr;
  int num_errors, cmp_count, rise_count, period, n, base;
  logic [1:0] r;
  logic [31:0] d;
  logic flag;
  typedef struct {logic [31:0] wd; logic [31:0] rd; int per;} rcp_row_t;
  // Select 0 ticks every cycle, select 1 every other cycle
  rcp_row_t rows [4] = '{'{32'h8000, 32'h8000, 2}, '{32'h8100, 32'h8100, 4},
    '{32'hD3FF, 32'h9300, 32}, '{32'h7F00, 32'h3F00, 0}};

  rcp_top u_rcp_top (.aclk, .aresetn, .axi_req, .axi_rsp, .psave, .wake_src, .deep_sleep_arm,
    .cur_clk_src, .posc_tick, .sys_tick, .posc_configured, .wdt_enable, .fail_safe_clock_monitor_enable,
    .rtc_enable, .rtc_on_low_power_rc_osc, .deep_sleep_watchdog_enable, .gpio_dir, .gpio_out, .reference_clock_pin,
    .cpu_clk_en, .sys_clk_en, .periph_clk_en, .ext_periph_en, .posc_en, .low_power_rc_osc_en,
    .fail_safe_clock_monitor_active, .rtc_run, .deep_sleep_watchdog_run, .wdt_clear, .wake_pulse, .resume_isr,
    .resume_clk_src, .pin_dir, .pin_out);
  rcp_refclk_sink u_rcp_refclk_sink (.aclk, .aresetn, .reference_clock_pin, .rise_count,
    .period);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Held low in reset so the tick never starts unknown
  always @(posedge aclk) posc_tick <= aresetn ? ~posc_tick : 1'b0;

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  task automatic expire();
    if (n >= 40) begin
      check("wait bound", 32'h1, 32'h0);
      conclude();
    end
  endtask : expire
  task automatic axi_wr(logic [7:0] a, logic [31:0] wd, logic [3:0] s);
    @(posedge aclk);
    axi_req.awaddr <= a;
    axi_req.wdata <= wd;
    axi_req.wstrb <= s;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    n = 0;
    do begin @(negedge aclk); n++; end while (axi_rsp.awready !== 1'b1 && n < 40);
    expire();
    @(posedge aclk);
    axi_req.awvalid <= 1'b0;
    axi_req.wvalid <= 1'b0;
    do begin @(negedge aclk); n++; end while (axi_rsp.bvalid !== 1'b1 && n < 40);
    expire();
    r = axi_rsp.bresp;
    @(posedge aclk);
    axi_req.bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(logic [7:0] a);
    @(posedge aclk);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    n = 0;
    do begin @(negedge aclk); n++; end while (axi_rsp.arready !== 1'b1 && n < 40);
    expire();
    @(posedge aclk);
    axi_req.arvalid <= 1'b0;
    do begin @(negedge aclk); n++; end while (axi_rsp.rvalid !== 1'b1 && n < 40);
    expire();
    r = axi_rsp.rresp;
    d = axi_rsp.rdata;
    @(posedge aclk);
    axi_req.rready <= 1'b0;
  endtask : axi_rd
  task automatic enter(logic op);
    @(posedge aclk);
    psave <= '{1'b1, op};
    @(posedge aclk);
    psave.exec <= 1'b0;
    @(negedge aclk);
  endtask : enter
  task automatic wake(rcp_wake_t w);
    @(posedge aclk);
    wake_src <= w;
    @(posedge aclk);
    wake_src <= '0;
    @(negedge aclk);
  endtask : wake

  initial begin
    {aresetn, deep_sleep_arm, wdt_enable, rtc_enable, deep_sleep_watchdog_enable} = '0;
    {sys_tick, posc_configured, fail_safe_clock_monitor_enable, rtc_on_low_power_rc_osc} = 4'hF;
    {axi_req, psave, wake_src, num_errors, cmp_count} = '0;
    cur_clk_src = 3'h5;
    gpio_dir = 16'h00F0;
    gpio_out = 16'hA5A5;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check("pin after reset", reference_clock_pin, 1'b0);
    axi_rd(RCP_CTRL_OFS);
    check("ctrl reset", d, 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      axi_wr(RCP_CTRL_OFS, rows[i].wd, 4'hF);
      check("write resp", r, RCP_RESP_OKAY);
      axi_rd(RCP_CTRL_OFS);
      check("ctrl read", d, rows[i].rd);
      base = rise_count;
      flag = 1'b0;
      for (n = 0; n < 200 && (rows[i].per == 0 || rise_count < base + 3); n++) begin
        @(negedge aclk);
        flag = flag | reference_clock_pin;
      end
      if (rows[i].per == 0) check("pin disabled", flag, 1'b0);
      else check("ref period", period, rows[i].per);
    end
    $display("table test done");
    axi_wr(RCP_CTRL_OFS, 32'hFF00, 4'h1);
    axi_rd(RCP_CTRL_OFS);
    check("lane 0 write", d, 32'h3F00);
    axi_wr(8'h08, 32'hFFFF, 4'hF);
    check("unmapped write", r, RCP_RESP_SLVERR);
    axi_rd(8'h08);
    check("unmapped read resp", r, RCP_RESP_SLVERR);
    check("unmapped read data", d, 32'h0);
    axi_wr(RCP_STAT_OFS, 32'hFF, 4'hF);
    check("status write", r, RCP_RESP_OKAY);
    $display("bus test done");
    wdt_enable <= 1'b1;
    axi_wr(RCP_CTRL_OFS, 32'hB000, 4'hF);
    enter(1'b0);
    check("idle clocks", {cpu_clk_en, sys_clk_en, periph_clk_en}, 3'b011);
    check("idle wdt clear", {wdt_clear, low_power_rc_osc_en}, 2'b11);
    axi_rd(RCP_STAT_OFS);
    check("idle status", d[3:0], 4'h1);
    wake('{1'b1, 1'b0, 1'b0});
    check("idle wake", {wake_pulse, cpu_clk_en, resume_isr}, 3'b111);
    $display("idle test done");
    enter(1'b1);
    check("sleep clocks", {cpu_clk_en, sys_clk_en, periph_clk_en}, 3'b000);
    check("sleep keeps", {ext_periph_en, posc_en, low_power_rc_osc_en}, 3'b111);
    check("sleep fail_safe_clock_monitor", {fail_safe_clock_monitor_active, wdt_clear}, 2'b01);
    base = rise_count;
    @(posedge aclk);
    gpio_dir <= 16'h0F0F;
    gpio_out <= 16'h1234;
    cur_clk_src <= 3'h2;
    repeat (40) @(negedge aclk);
    check("frozen pins", {pin_dir, pin_out}, {16'h00F0, 16'hA5A5});
    check("held source", resume_clk_src, 3'h5);
    check("ref in sleep", rise_count > base + 5, 1'b1);
    wake('{1'b0, 1'b1, 1'b0});
    check("wdt wake", {wake_pulse, cpu_clk_en, resume_isr}, 3'b110);
    axi_wr(RCP_CTRL_OFS, 32'h8000, 4'hF);
    enter(1'b1);
    repeat (3) @(negedge aclk);
    check("sleep stop", {posc_en, reference_clock_pin}, 2'b00);
    wake('{1'b1, 1'b0, 1'b0});
    check("pin tracking", {pin_dir, pin_out}, {16'h0F0F, 16'h1234});
    $display("sleep test done");
    @(posedge aclk);
    psave <= '{1'b1, 1'b1};
    wake_src.irq <= 1'b1;
    @(posedge aclk);
    psave.exec <= 1'b0;
    wake_src.irq <= 1'b0;
    flag = 1'b0;
    repeat (3) begin
      @(negedge aclk);
      flag = flag | (wake_pulse & resume_isr);
    end
    check("coincident wake", {flag, cpu_clk_en}, 2'b11);
    @(posedge aclk);
    {deep_sleep_arm, rtc_enable, deep_sleep_watchdog_enable} <= 3'b111;
    enter(1'b1);
    check("deep sleep", {rtc_run, deep_sleep_watchdog_run, periph_clk_en, cpu_clk_en}, 4'hC);
    wake('{1'b1, 1'b0, 1'b0});
    check("deep irq", cpu_clk_en, 1'b0);
    @(posedge aclk);
    deep_sleep_arm <= 1'b0;
    wake('{1'b0, 1'b0, 1'b1});
    check("reset wake", {wake_pulse, cpu_clk_en}, 2'b11);
    $display("power test done");
    // Second reset from a running, enabled state
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check("mid reset outputs", {cpu_clk_en, wake_pulse, reference_clock_pin}, 3'b100);
    axi_rd(RCP_CTRL_OFS);
    check("mid reset ctrl", d, 32'h0);
    $display("mid reset test done");
    conclude();
  end
endmodule : tb_rcp_top
